// ---- hw/pmon_i2c_pkg.sv ----
package pmon_i2c_pkg;

    localparam int          CLK_PERIOD_NS    = 4;
    // Strap pins are static; a short settle after reset is enough
    localparam int          STRAP_SETTLE_NS  = 200;
    localparam int          STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          STRAP_CNT_W      = 8;
    localparam int          FAST_MODE_KHZ    = 400;
    localparam int          SCL_PERIOD_CYC   = 1000000 / (FAST_MODE_KHZ * CLK_PERIOD_NS);

    localparam logic [2:0]  ADDR_PREFIX      = 3'h4;
    localparam logic [6:0]  CMD_RESET        = 7'h00;
    localparam logic [7:0]  RD_FILL          = 8'h00;
    localparam logic [3:0]  BITS_PER_BYTE    = 4'h8;
    localparam logic [3:0]  LAST_TX_BIT      = 4'h7;

    localparam int          CMD_VOLT_CONT    = 0;
    localparam int          CMD_VOLT_ONCE    = 1;
    localparam int          CMD_CURR_CONT    = 2;
    localparam int          CMD_CURR_ONCE    = 3;
    localparam int          CMD_VOLT_RANGE   = 4;
    localparam int          CMD_STATUS_RD    = 6;
    localparam int          CMD_EXT_FLAG     = 7;
    localparam logic [1:0]  EXT_SEL_NONE     = 2'h0;

    // Gray codes along idle, address, ack, data
    typedef enum logic [2:0] {
        ST_IDLE     = 3'h0,
        ST_ADDR     = 3'h1,
        ST_ADDR_ACK = 3'h3,
        ST_WR_BYTE  = 3'h2,
        ST_WR_ACK   = 3'h6,
        ST_RD_BYTE  = 3'h7,
        ST_RD_ACK   = 3'h5
    } i2c_state_t;

endpackage

// ---- hw/power_monitor_i2c_command_slave.sv ----
`timescale 1ns/100ps
module power_monitor_i2c_command_slave (
    input  wire logic        REF_CLK,
    input  wire logic        RESETN,
    input  wire logic        CE,
    input  wire logic        SCL,
    input  wire logic        SDA_IN,
    output logic             SDA_OUT,
    output logic             SDA_OE,
    input  wire logic [1:0]  ADDR_STRAP_LOW,
    input  wire logic [1:0]  ADDR_STRAP_HIGH,
    input  wire logic        ADC_VOLT_DONE,
    input  wire logic [11:0] ADC_VOLT_DATA,
    input  wire logic        ADC_CURR_DONE,
    input  wire logic [11:0] ADC_CURR_DATA,
    input  wire logic [7:0]  ALERT_STATUS,
    output logic             VOLT_CONTINUOUS,
    output logic             CURR_CONTINUOUS,
    output logic             VOLT_ONCE_REQ,
    output logic             CURR_ONCE_REQ,
    output logic             VOLT_DIVIDER_SELECT,
    output logic             EXT_WR_STROBE,
    output logic [1:0]       EXT_WR_SEL,
    output logic [7:0]       EXT_WR_DATA
);

    logic [1:0]                         scl_sync, sda_sync, byte_idx, wr_idx, chan_sel, ext_sel, next_idx;
    logic [3:0]                         strap_meta, strap_sync, bitcnt;
    logic [pmon_i2c_pkg::STRAP_CNT_W-1:0] strap_cnt;
    logic [6:0]                         own_addr, cfg;
    logic [7:0]                         rx_shift, tx_shift, wr_byte, next_tx;
    logic [11:0]                        volt_res, curr_res;
    pmon_i2c_pkg::i2c_state_t           state;
    logic                               scl_d, sda_d, scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
    logic                               addr_ready, rd_dir, master_ack, wr_valid, ext_pend, once_busy, cmd_take;

    // Readback formatting; chan is {current, voltage}
    function automatic logic [7:0] read_byte(
        input logic [1:0]  idx,
        input logic        stat,
        input logic [1:0]  chan,
        input logic [11:0] v,
        input logic [11:0] i,
        input logic [7:0]  st
    );
        read_byte = pmon_i2c_pkg::RD_FILL;
        if (stat) begin
            if (idx == 2'h0) begin
                read_byte = st;
            end
        end else if (chan == 2'h3) begin
            case (idx)
                2'h0:    read_byte = v[11:4];
                2'h1:    read_byte = i[11:4];
                2'h2:    read_byte = {v[3:0], i[3:0]};
                default: read_byte = pmon_i2c_pkg::RD_FILL;
            endcase
        end else if (chan != 2'h0) begin
            if (idx == 2'h0) begin
                read_byte = chan[0] ? v[11:4] : i[11:4];
            end else if (idx == 2'h1) begin
                read_byte = chan[0] ? {v[3:0], 4'h0} : {i[3:0], 4'h0};
            end
        end
    endfunction

    // Oversampling at 250 MHz leaves hundreds of samples per 400 kHz bit
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_d    <= 1'b1;
            sda_d    <= 1'b1;
        end else if (CE) begin
            scl_sync <= {scl_sync[0], SCL};
            sda_sync <= {sda_sync[0], SDA_IN};
            scl_d    <= scl_sync[1];
            sda_d    <= sda_sync[1];
        end
    end

    assign scl_s     = scl_sync[1];
    assign sda_s     = sda_sync[1];
    assign scl_rise  = scl_s && !scl_d;
    assign scl_fall  = !scl_s && scl_d;
    assign start_det = scl_s && scl_d && sda_d && !sda_s;
    assign stop_det  = scl_s && scl_d && !sda_d && sda_s;
    assign once_busy = cfg[pmon_i2c_pkg::CMD_VOLT_ONCE] || cfg[pmon_i2c_pkg::CMD_CURR_ONCE];
    assign next_idx  = (state == pmon_i2c_pkg::ST_ADDR_ACK) ? 2'h0 :
                       ((byte_idx == 2'h3) ? 2'h3 : byte_idx + 2'h1);
    assign next_tx   = read_byte(next_idx, cfg[pmon_i2c_pkg::CMD_STATUS_RD], chan_sel,
                                 volt_res, curr_res, ALERT_STATUS);

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            strap_meta <= 4'h0;
            strap_sync <= 4'h0;
        end else if (CE) begin
            strap_meta <= {ADDR_STRAP_HIGH, ADDR_STRAP_LOW};
            strap_sync <= strap_meta;
        end
    end

    // Captured once; later strap movement cannot move the address
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            strap_cnt  <= '0;
            addr_ready <= 1'b0;
            own_addr   <= 7'h00;
        end else if (CE && !addr_ready) begin
            if (strap_cnt == pmon_i2c_pkg::STRAP_SETTLE_CYC[pmon_i2c_pkg::STRAP_CNT_W-1:0]) begin
                own_addr   <= {pmon_i2c_pkg::ADDR_PREFIX, strap_sync};
                addr_ready <= 1'b1;
            end else begin
                strap_cnt <= strap_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state      <= pmon_i2c_pkg::ST_IDLE;
            bitcnt     <= 4'h0;
            rx_shift   <= 8'h00;
            tx_shift   <= 8'h00;
            rd_dir     <= 1'b0;
            byte_idx   <= 2'h0;
            master_ack <= 1'b0;
            SDA_OE     <= 1'b0;
            wr_valid   <= 1'b0;
            wr_byte    <= 8'h00;
            wr_idx     <= 2'h0;
        end else if (CE) begin
            wr_valid <= 1'b0;
            if (stop_det) begin
                state  <= pmon_i2c_pkg::ST_IDLE;
                SDA_OE <= 1'b0;
            end else if (start_det) begin
                state  <= pmon_i2c_pkg::ST_ADDR;
                bitcnt <= 4'h0;
                SDA_OE <= 1'b0;
            end else begin
                case (state)
                    pmon_i2c_pkg::ST_ADDR: begin
                        if (scl_rise) begin
                            rx_shift <= {rx_shift[6:0], sda_s};
                            bitcnt   <= bitcnt + 4'h1;
                        end else if (scl_fall && bitcnt == pmon_i2c_pkg::BITS_PER_BYTE) begin
                            // Reads are refused while a one-shot conversion runs
                            if (addr_ready && rx_shift[7:1] == own_addr &&
                                !(rx_shift[0] && once_busy)) begin
                                state  <= pmon_i2c_pkg::ST_ADDR_ACK;
                                SDA_OE <= 1'b1;
                                rd_dir <= rx_shift[0];
                            end else begin
                                state <= pmon_i2c_pkg::ST_IDLE;
                            end
                        end
                    end
                    pmon_i2c_pkg::ST_ADDR_ACK: begin
                        if (scl_fall) begin
                            bitcnt   <= 4'h0;
                            byte_idx <= next_idx;
                            if (rd_dir) begin
                                tx_shift <= next_tx;
                                SDA_OE   <= !next_tx[7];
                                state    <= pmon_i2c_pkg::ST_RD_BYTE;
                            end else begin
                                SDA_OE <= 1'b0;
                                state  <= pmon_i2c_pkg::ST_WR_BYTE;
                            end
                        end
                    end
                    pmon_i2c_pkg::ST_WR_BYTE: begin
                        if (scl_rise) begin
                            rx_shift <= {rx_shift[6:0], sda_s};
                            bitcnt   <= bitcnt + 4'h1;
                        end else if (scl_fall && bitcnt == pmon_i2c_pkg::BITS_PER_BYTE) begin
                            state    <= pmon_i2c_pkg::ST_WR_ACK;
                            SDA_OE   <= 1'b1;
                            wr_valid <= 1'b1;
                            wr_byte  <= rx_shift;
                            wr_idx   <= byte_idx;
                            byte_idx <= (byte_idx == 2'h3) ? 2'h3 : byte_idx + 2'h1;
                        end
                    end
                    pmon_i2c_pkg::ST_WR_ACK: begin
                        if (scl_fall) begin
                            SDA_OE <= 1'b0;
                            bitcnt <= 4'h0;
                            state  <= pmon_i2c_pkg::ST_WR_BYTE;
                        end
                    end
                    pmon_i2c_pkg::ST_RD_BYTE: begin
                        if (scl_fall) begin
                            if (bitcnt == pmon_i2c_pkg::LAST_TX_BIT) begin
                                SDA_OE <= 1'b0;
                                state  <= pmon_i2c_pkg::ST_RD_ACK;
                            end else begin
                                tx_shift <= {tx_shift[6:0], 1'b0};
                                SDA_OE   <= !tx_shift[6];
                                bitcnt   <= bitcnt + 4'h1;
                            end
                        end
                    end
                    pmon_i2c_pkg::ST_RD_ACK: begin
                        if (scl_rise) begin
                            master_ack <= !sda_s;
                        end else if (scl_fall) begin
                            if (master_ack) begin
                                tx_shift <= next_tx;
                                SDA_OE   <= !next_tx[7];
                                byte_idx <= next_idx;
                                bitcnt   <= 4'h0;
                                state    <= pmon_i2c_pkg::ST_RD_BYTE;
                            end else begin
                                state <= pmon_i2c_pkg::ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        state <= pmon_i2c_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end
    assign cmd_take = wr_valid && wr_idx == 2'h0 && !wr_byte[pmon_i2c_pkg::CMD_EXT_FLAG];
    // A new command overrides a completion arriving in the same cycle
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            cfg      <= pmon_i2c_pkg::CMD_RESET;
            chan_sel <= 2'h0;
        end else if (CE) begin
            if (cmd_take) begin
                cfg      <= wr_byte[6:0];
                chan_sel <= {wr_byte[pmon_i2c_pkg::CMD_CURR_CONT] || wr_byte[pmon_i2c_pkg::CMD_CURR_ONCE],
                             wr_byte[pmon_i2c_pkg::CMD_VOLT_CONT] || wr_byte[pmon_i2c_pkg::CMD_VOLT_ONCE]};
            end else begin
                if (ADC_VOLT_DONE) begin
                    cfg[pmon_i2c_pkg::CMD_VOLT_ONCE] <= 1'b0;
                end
                if (ADC_CURR_DONE) begin
                    cfg[pmon_i2c_pkg::CMD_CURR_ONCE] <= 1'b0;
                end
            end
        end
    end
    assign VOLT_CONTINUOUS     = cfg[pmon_i2c_pkg::CMD_VOLT_CONT];
    assign CURR_CONTINUOUS     = cfg[pmon_i2c_pkg::CMD_CURR_CONT];
    assign VOLT_DIVIDER_SELECT = cfg[pmon_i2c_pkg::CMD_VOLT_RANGE];
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            VOLT_ONCE_REQ <= 1'b0;
            CURR_ONCE_REQ <= 1'b0;
            SDA_OUT       <= 1'b0;
        end else if (CE) begin
            VOLT_ONCE_REQ <= cmd_take && wr_byte[pmon_i2c_pkg::CMD_VOLT_ONCE];
            CURR_ONCE_REQ <= cmd_take && wr_byte[pmon_i2c_pkg::CMD_CURR_ONCE];
            SDA_OUT       <= 1'b0;
        end
    end
    // Results are live: an update mid-read may mix old and new samples
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            volt_res <= 12'h000;
            curr_res <= 12'h000;
        end else if (CE) begin
            if (ADC_VOLT_DONE) begin
                volt_res <= ADC_VOLT_DATA;
            end else if (cmd_take) begin
                volt_res <= 12'h000;
            end
            if (ADC_CURR_DONE) begin
                curr_res <= ADC_CURR_DATA;
            end else if (cmd_take) begin
                curr_res <= 12'h000;
            end
        end
    end
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            ext_pend      <= 1'b0;
            ext_sel       <= pmon_i2c_pkg::EXT_SEL_NONE;
            EXT_WR_STROBE <= 1'b0;
            EXT_WR_SEL    <= pmon_i2c_pkg::EXT_SEL_NONE;
            EXT_WR_DATA   <= 8'h00;
        end else if (CE) begin
            EXT_WR_STROBE <= 1'b0;
            if (wr_valid && wr_idx == 2'h0) begin
                ext_pend <= wr_byte[pmon_i2c_pkg::CMD_EXT_FLAG];
                ext_sel  <= wr_byte[1:0];
            end else if (wr_valid && wr_idx == 2'h1) begin
                ext_pend <= 1'b0;
                if (ext_pend && !wr_byte[7] && ext_sel != pmon_i2c_pkg::EXT_SEL_NONE) begin
                    EXT_WR_STROBE <= 1'b1;
                    EXT_WR_SEL    <= ext_sel;
                    EXT_WR_DATA   <= wr_byte;
                end
            end
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN || !CE);
    sequence s_addr_done;
        state == pmon_i2c_pkg::ST_ADDR && scl_fall && bitcnt == pmon_i2c_pkg::BITS_PER_BYTE;
    endsequence
    sequence s_addr_hit;
        addr_ready && rx_shift[7:1] == own_addr && !(rx_shift[0] && once_busy);
    endsequence
    sequence s_ack_high;
        state == pmon_i2c_pkg::ST_ADDR_ACK && scl_s;
    endsequence

    a_start_to_addr: assert property (start_det && !stop_det |=> state == pmon_i2c_pkg::ST_ADDR)
        else $error("start not followed by address phase");
    a_stop_release: assert property (stop_det |=> state == pmon_i2c_pkg::ST_IDLE && !SDA_OE)
        else $error("stop did not release the bus");
    a_addr_ack: assert property (s_addr_done ##0 s_addr_hit |=> SDA_OE && state == pmon_i2c_pkg::ST_ADDR_ACK)
        else $error("own address not acknowledged");
    a_ack_hold: assert property (s_ack_high |-> SDA_OE)
        else $error("acknowledge released during clock high");
    a_mismatch_idle: assert property (s_addr_done ##0 (rx_shift[7:1] != own_addr) |=>
        state == pmon_i2c_pkg::ST_IDLE && !SDA_OE)
        else $error("foreign address not ignored");
    a_sda_low_phase: assert property ($changed(SDA_OE) |-> !$past(scl_s) || !SDA_OE)
        else $error("data changed while clock high");
    a_once_refuse: assert property (s_addr_done ##0 (rx_shift[0] && once_busy) |=> !SDA_OE)
        else $error("read acknowledged during one-shot conversion");
    a_cmd_store: assert property (cmd_take |=> cfg[6:4] == $past(wr_byte[6:4]) &&
        cfg[pmon_i2c_pkg::CMD_VOLT_CONT] == $past(wr_byte[0]))
        else $error("command byte not stored");
    a_once_clear: assert property (ADC_VOLT_DONE && !cmd_take |=> !cfg[pmon_i2c_pkg::CMD_VOLT_ONCE])
        else $error("one-shot voltage bit did not self-clear");
    a_zero_result: assert property (cmd_take && !ADC_VOLT_DONE |=> volt_res == 12'h000)
        else $error("stale voltage result after new command");
    a_strap_fixed: assert property (addr_ready && $past(addr_ready) |-> $stable(own_addr))
        else $error("slave address moved after capture");
    a_prefix: assert property (addr_ready |-> own_addr[6:4] == pmon_i2c_pkg::ADDR_PREFIX)
        else $error("address prefix wrong");

endmodule

// ---- sim/i2c_master_model.sv ----
`timescale 1ns/100ps
module i2c_master_model (
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda
);
    // Clock stands high and data released between frames
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic start();
        sda = 1'b1;
        #20 scl = 1'b1;
        #40 sda = 1'b0;
        #40 scl = 1'b0;
    endtask
    task automatic stop();
        #20 sda = 1'b0;
        #20 scl = 1'b1;
        #20 sda = 1'b1;
        #40;
    endtask
    // Data moves only mid-low, so it never changes under a high clock
    task automatic byte_io(input logic [7:0] d, input logic mack, output logic [7:0] r, output logic sack);
        logic [8:0] bits;
        bits = {d, mack};
        for (int i = 8; i >= 0; i--) begin
            #20 sda = bits[i];
            #20 scl = 1'b1;
            #20;
            if (i > 0) r = {r[6:0], sda_line};
            else sack = sda_line;
            #20 scl = 1'b0;
        end
    endtask
endmodule

// ---- sim/test_power_monitor_i2c_command_slave.sv ----
`timescale 1ns/100ps
module test_power_monitor_i2c_command_slave;
    localparam logic [7:0] DEV_BYTE = 8'h9a;
    localparam logic [6:0] DEV      = DEV_BYTE[7:1];
    logic        ref_clk, resetn, v_done, c_done, volt_continuous, c_cont, v_once, c_once, v_div, ext_stb;
    logic        scl, sda_m, sda_oe, sda_out;
    logic [1:0]  strap_lo, strap_hi, ext_sel;
    logic [11:0] v_data, c_data;
    logic [7:0]  alert, ext_data;
    int          mismatches, total_checks, cycles, once_cnt, ext_cnt;
    // Device drives its data output only while enabled; pull-up otherwise
    wire         sda_line = sda_m & (~sda_oe | sda_out);

    i2c_master_model m (.sda_line(sda_line), .scl(scl), .sda(sda_m));
    power_monitor_i2c_command_slave dut (.REF_CLK(ref_clk), .RESETN(resetn), .CE(1'b1), .SCL(scl),
        .SDA_IN(sda_line), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .ADDR_STRAP_LOW(strap_lo), .ADDR_STRAP_HIGH(strap_hi),
        .ADC_VOLT_DONE(v_done), .ADC_VOLT_DATA(v_data), .ADC_CURR_DONE(c_done), .ADC_CURR_DATA(c_data),
        .ALERT_STATUS(alert), .VOLT_CONTINUOUS(volt_continuous), .CURR_CONTINUOUS(c_cont), .VOLT_ONCE_REQ(v_once),
        .CURR_ONCE_REQ(c_once), .VOLT_DIVIDER_SELECT(v_div), .EXT_WR_STROBE(ext_stb), .EXT_WR_SEL(ext_sel),
        .EXT_WR_DATA(ext_data));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // Pulse counters catch strobes that a poll would miss
    always @(posedge ref_clk) begin
        once_cnt <= once_cnt + int'(v_once) + 16 * int'(c_once);
        ext_cnt  <= ext_cnt + int'(ext_stb);
        cycles   <= cycles + 1;
        if (cycles == 30000) begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (mismatches == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Reads ack every byte but the last; a refused address ends the frame
    task automatic xfer(input logic [6:0] a, input logic rd, input logic ack, input int n, input logic [23:0] d);
        logic [7:0] r;
        logic       s;
        @(posedge ref_clk) #1;
        m.start();
        m.byte_io({a, rd}, 1'b1, r, s);
        chk(24'(s), 24'(!ack));
        for (int i = n - 1; ack && i >= 0; i--) begin
            m.byte_io(rd ? 8'hff : d[8*i +: 8], rd ? (i == 0) : 1'b1, r, s);
            chk(rd ? 24'(r) : 24'(s), rd ? 24'(d[8*i +: 8]) : 24'h0);
        end
        m.stop();
    endtask
    task automatic adc(input logic vd, input logic cd, input logic [11:0] v, input logic [11:0] c);
        @(posedge ref_clk) #1;
        {v_done, c_done, v_data, c_data} = {vd, cd, v, c};
        @(posedge ref_clk) #1;
        {v_done, c_done} = 2'h0;
    endtask

    task automatic t_address();
        xfer(DEV, 1'b0, 1'b1, 0, 24'h0);
        strap_lo = 2'h0;
        xfer(DEV, 1'b0, 1'b1, 0, 24'h0);
        xfer(DEV ^ 7'h01, 1'b0, 1'b0, 0, 24'h0);
    endtask
    task automatic t_continuous();
        xfer(DEV, 1'b0, 1'b1, 1, 24'h15);
        chk(24'({volt_continuous, c_cont, v_div}), 24'h7);
        xfer(DEV, 1'b1, 1'b1, 3, 24'h0);
        adc(1'b1, 1'b1, 12'habc, 12'h123);
        xfer(DEV, 1'b1, 1'b1, 3, 24'hab12c3);
    endtask
    task automatic t_once();
        int c0;
        c0 = once_cnt;
        xfer(DEV, 1'b0, 1'b1, 1, 24'h02);
        chk(24'(once_cnt - c0), 24'h1);
        c0 = once_cnt;
        chk(24'({volt_continuous, c_cont, v_div}), 24'h0);
        xfer(DEV, 1'b1, 1'b0, 0, 24'h0);
        adc(1'b1, 1'b0, 12'h5a6, 12'h0);
        xfer(DEV, 1'b1, 1'b1, 2, 24'h5a60);
        xfer(DEV, 1'b0, 1'b1, 1, 24'h08);
        chk(24'(once_cnt - c0), 24'h10);
        xfer(DEV, 1'b1, 1'b0, 0, 24'h0);
        adc(1'b0, 1'b1, 12'h000, 12'h7e1);
        xfer(DEV, 1'b1, 1'b1, 2, 24'h7e10);
    endtask
    task automatic t_status_ext();
        int e0;
        alert = 8'h3c;
        xfer(DEV, 1'b0, 1'b1, 1, 24'h40);
        xfer(DEV, 1'b1, 1'b1, 1, 24'h3c);
        e0 = ext_cnt;
        xfer(DEV, 1'b0, 1'b1, 2, 24'h8305);
        chk(24'({2'(ext_cnt - e0), ext_sel, ext_data}), 24'h705);
    endtask

    initial begin
        {resetn, v_done, c_done, v_data, c_data, alert} = '0;
        {strap_lo, strap_hi} = {2'h1, 2'h3};
        repeat (5) @(posedge ref_clk);
        #1 resetn = 1'b1;
        chk(24'({volt_continuous, c_cont, v_div, ext_sel, ext_data}), 24'h0);
        repeat (100) @(posedge ref_clk);
        t_address();
        t_continuous();
        t_once();
        t_status_ext();
        end_of_test();
    end
endmodule
